// ===== hw/sbs_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the status flag block.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per aligned word.
// Notes:   Definitions only.
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

`define SBS_OFS_STATUS         12'h28C
`define SBS_OFS_STATUS_SECOND  12'h44C
`define SBS_OFS_CONTROL        12'h288
`define SBS_OFS_OWN_ADDRESS    12'h294

`define SBS_BIT_BYTE_DONE      7
`define SBS_BIT_ADDRESSED      6
`define SBS_BIT_BUS_BUSY       5
`define SBS_BIT_ARB_LOST       4
`define SBS_BIT_TARGET_RW      2
`define SBS_BIT_IRQ_PENDING    1
`define SBS_BIT_RX_ACK         0

`define SBS_CTL_ENABLE         7
`define SBS_CTL_IRQ_ENABLE     6
`define SBS_CTL_CONTROLLER     5
`define SBS_CTL_TRANSMIT       4
`define SBS_CTL_TX_ACK         3
`define SBS_CTL_REPEAT_START   2

`define SBS_STATUS_RESET       8'h81
`define SBS_CONTROL_RESET      8'h00
`define SBS_BITS_PER_BYTE      4'h9

`endif

// ===== hw/sbs_pkg.sv
// Purpose: Types shared by the status flag block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Types only.
package sbs_pkg;
   typedef enum logic [1:0] {
      SBS_LINK_IDLE,
      SBS_LINK_ADDRESS,
      SBS_LINK_DATA
   } sbs_link_phase_t;
endpackage : sbs_pkg

// ===== hw/sbs_event_if.sv
// Purpose: Bus events carried from the link sampler to the flag logic.
// Assumes: All signals on hclk; events are one-cycle pulses.
// Notes:   Produced by sbs_pin_sync, consumed by sbs_status_top.
`timescale 1ns/1ps
interface sbs_event_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_level;
   logic scl_level;
   logic start_seen;
   logic stop_seen;
   modport source (output scl_rise, output scl_fall, output sda_level, output scl_level,
                   output start_seen, output stop_seen);
   modport sink   (input scl_rise, input scl_fall, input sda_level, input scl_level,
                   input start_seen, input stop_seen);
endinterface : sbs_event_if

// ===== hw/sbs_pin_sync.sv
// Purpose: Three-stage sampling of SCL and SDA with edge, START and STOP detection.
// Assumes: Pins are asynchronous to hclk; SCL far slower than hclk.
// Notes:   A change counts once stages one and two agree.
`timescale 1ns/1ps
module sbs_pin_sync (
   input  wire logic   hclk,
   input  wire logic   hresetn,
   input  wire logic   scl_in,
   input  wire logic   sda_in,
   sbs_event_if.source ev
);
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic       scl_q;
   logic       sda_q;

   wire scl_agree = (scl_sync[1] == scl_sync[2]);
   wire sda_agree = (sda_sync[1] == sda_sync[2]);
   wire next_scl  = scl_agree ? scl_sync[2] : scl_q;
   wire next_sda  = sda_agree ? sda_sync[2] : sda_q;

   // Stage zero feeds only stage one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         scl_q    <= next_scl;
         sda_q    <= next_sda;
      end
   end

   assign ev.scl_level  = scl_q;
   assign ev.sda_level  = sda_q;
   assign ev.scl_rise   = next_scl & ~scl_q;
   assign ev.scl_fall   = ~next_scl & scl_q;
   // SDA moving while SCL stays high
   assign ev.start_seen = scl_q & next_scl & sda_q & ~next_sda;
   assign ev.stop_seen  = scl_q & next_scl & ~sda_q & next_sda;
endmodule : sbs_pin_sync

// ===== hw/sbs_ahb_slave.sv
// Purpose: AHB-Lite slave front end producing register read and write strobes.
// Assumes: Single word transfers; zero wait states.
// Notes:   Write strobe is issued in the data phase with hwdata.
`timescale 1ns/1ps
module sbs_ahb_slave #(
   parameter int ADDR_W = 12
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   output logic                   wr_en,
   output logic                   rd_en,
   output logic [ADDR_W-1:0]      reg_addr
);
   logic              wr_pend;
   logic [ADDR_W-1:0] addr_q;

   wire accept = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         addr_q  <= '0;
      end else if (hready) begin
         wr_pend <= accept & hwrite;
         if (accept)
            addr_q <= haddr[ADDR_W-1:0];
      end
   end

   // Held write address; reads decode haddr so back-to-back stays apart
   assign rd_en    = accept & ~hwrite;
   assign wr_en    = wr_pend;
   assign reg_addr = addr_q;
endmodule : sbs_ahb_slave

// ===== hw/sbs_status_top.sv
// Purpose: Status flag logic of a two-wire serial bus controller with AHB-Lite register access.
// Assumes: hclk 125 MHz; SCL/SDA pins asynchronous; datapath supplies driven levels and strobes.
// Notes:   Zero wait-state slave; unmapped addresses read zero and ignore writes.
// Notes on behaviour
// [RULE1] Status is read-only except interrupt-pending and arbitration-lost, software-clearable.
// [RULE2] Reset clears status bits except byte-done and received-ack, which reset high.
// [RULE3] Byte-done reads zero during a byte; set at falling edge of ninth clock.
// [RULE4] Own address match sets addressed-as-target; interrupt raised when enabled.
// [RULE5] Any control register write clears addressed-as-target.
// [RULE6] START sets bus-busy; STOP clears it; one means busy.
// [RULE7] SDA low while driving high as transmitting controller loses arbitration.
// [RULE8] SDA low during our high acknowledge as receiving controller loses arbitration.
// [RULE9] START attempted while bus busy loses arbitration.
// [RULE10] Repeated START requested in target mode loses arbitration.
// [RULE11] Unrequested STOP on the bus loses arbitration.
// [RULE12] Arbitration-lost and interrupt-pending clear only when software writes zero.
// [RULE13] While addressed, target read/write holds the calling address R/W bit.
// [RULE14] Software trusts target read/write only after completed transfer with address match.
// [RULE15] Interrupt-pending and interrupt enable together drive the interrupt request.
// [RULE16] Byte completion, own address match in receive, or lost arbitration set interrupt-pending.
// [RULE17] Received-ack captures SDA on ninth clock after eight transmitted bits.
// [RULE18] Lost arbitration clears controller-select without a STOP.
// [RULE19] Clearing interrupt enable blocks requests but keeps pending flag.
// [RULE20] Byte-done cleared by data read in receive or data write in transmit.
// [RULE21] Unused status bit reads zero; writes to it do nothing.
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_status_top
   import sbs_pkg::*;
#(
   parameter int        ADDR_W = 12,
   parameter logic [6:0] OWN_ADDRESS_RESET = 7'h00
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        hready,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        sda_drive_high,
   input  wire logic        data_read_strobe,
   input  wire logic        data_write_strobe,
   input  wire logic        start_request,
   output logic             control_write_strobe,
   output logic [7:0]       serial_bus_control,
   output logic             irq
);
   sbs_event_if ev ();

   logic              wr_en;
   logic              rd_en;
   logic [ADDR_W-1:0] reg_addr;

   sbs_pin_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .ev      (ev)
   );

   sbs_ahb_slave #(.ADDR_W(ADDR_W)) u_ahb (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .hsel     (hsel),
      .haddr    (haddr),
      .htrans   (htrans),
      .hwrite   (hwrite),
      .hsize    (hsize),
      .hready   (hready),
      .wr_en    (wr_en),
      .rd_en    (rd_en),
      .reg_addr (reg_addr)
   );

   // Flags and control state
   logic            byte_done_flag;
   logic            addressed_as_target_flag;
   logic            bus_busy_flag;
   logic            arbitration_lost_flag;
   logic            target_read_write_bit;
   logic            interrupt_pending_flag;
   logic            received_ack_bit;
   logic [7:0]      control;
   logic [6:0]      own_address;
   logic [3:0]      bit_count;
   logic [7:0]      shift;
   sbs_link_phase_t phase;
   logic            stop_requested;

   wire interrupt_enable_bit   = control[`SBS_CTL_IRQ_ENABLE];
   wire controller_select_bit  = control[`SBS_CTL_CONTROLLER];
   wire transmit_direction_bit = control[`SBS_CTL_TRANSMIT];
   wire tx_ack_high            = control[`SBS_CTL_TX_ACK];

   wire sel_status  = (reg_addr == ADDR_W'(`SBS_OFS_STATUS)) ||
                      (reg_addr == ADDR_W'(`SBS_OFS_STATUS_SECOND));
   wire sel_control = (reg_addr == ADDR_W'(`SBS_OFS_CONTROL));
   wire sel_own     = (reg_addr == ADDR_W'(`SBS_OFS_OWN_ADDRESS));
   wire wr_status   = wr_en & sel_status;
   wire wr_control  = wr_en & sel_control;
   wire wr_own      = wr_en & sel_own;
   // Read decode in the address phase; a read right behind a write
   // to the same register still returns the old value
   wire rd_status   = (haddr[ADDR_W-1:0] == ADDR_W'(`SBS_OFS_STATUS)) ||
                      (haddr[ADDR_W-1:0] == ADDR_W'(`SBS_OFS_STATUS_SECOND));
   wire rd_control  = (haddr[ADDR_W-1:0] == ADDR_W'(`SBS_OFS_CONTROL));
   wire rd_own      = (haddr[ADDR_W-1:0] == ADDR_W'(`SBS_OFS_OWN_ADDRESS));

   // Byte framing on the bus
   wire ninth_fall   = ev.scl_fall & (bit_count == `SBS_BITS_PER_BYTE);
   wire ack_rise     = ev.scl_rise & (bit_count == 4'h8);
   wire addr_done    = ninth_fall & (phase == SBS_LINK_ADDRESS);
   wire addr_match   = (shift[7:1] == own_address) & ~controller_select_bit;
   wire in_byte      = (phase != SBS_LINK_IDLE) & (bit_count != 4'h0);

   // Arbitration loss causes
   wire lost_tx      = controller_select_bit & ev.scl_rise & (bit_count < 4'h8) &
                       (transmit_direction_bit | phase == SBS_LINK_ADDRESS) &
                       sda_drive_high & ~ev.sda_level; // [RULE7]
   wire lost_ack     = controller_select_bit & ack_rise & ~transmit_direction_bit &
                       (phase == SBS_LINK_DATA) & tx_ack_high & ~ev.sda_level; // [RULE8]
   wire [7:0] next_ctl = wr_control ? hwdata[7:0] : control;
   wire lost_start   = start_request & bus_busy_flag & ~controller_select_bit; // [RULE9]
   wire lost_rsta    = wr_control & hwdata[`SBS_CTL_REPEAT_START] & ~controller_select_bit; // [RULE10]
   wire lost_stop    = ev.stop_seen & controller_select_bit & ~stop_requested; // [RULE11]
   wire lost_any     = lost_tx | lost_ack | lost_start | lost_rsta | lost_stop;

   wire set_irq      = (ninth_fall & (phase == SBS_LINK_DATA)) |
                       (addr_done & (addr_match | controller_select_bit)) | lost_any; // [RULE16]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_count      <= 4'h0;
         shift          <= 8'h00;
         phase          <= SBS_LINK_IDLE;
         stop_requested <= 1'b0;
      end else begin
         if (ev.start_seen) begin
            bit_count <= 4'h0;
            phase     <= SBS_LINK_ADDRESS;
         end else if (ev.stop_seen) begin
            bit_count <= 4'h0;
            phase     <= SBS_LINK_IDLE;
         end else if (ninth_fall) begin
            bit_count <= 4'h0;
            phase     <= (phase == SBS_LINK_IDLE) ? SBS_LINK_IDLE : SBS_LINK_DATA;
         end else if (ev.scl_rise & phase != SBS_LINK_IDLE) begin
            bit_count <= bit_count + 4'h1;
            if (bit_count < 4'h8)
               shift <= {shift[6:0], ev.sda_level};
         end
         // A controller-select fall from software is a requested STOP
         if (controller_select_bit & ~next_ctl[`SBS_CTL_CONTROLLER])
            stop_requested <= 1'b1;
         else if (ev.stop_seen | ev.start_seen)
            stop_requested <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control     <= `SBS_CONTROL_RESET;
         own_address <= OWN_ADDRESS_RESET;
      end else begin
         if (lost_any)
            control <= {next_ctl[7:6], 1'b0, next_ctl[4:3], 3'h0}; // [RULE18]
         else if (wr_control)
            control <= {hwdata[7:3], 3'h0};
         if (wr_own)
            own_address <= hwdata[7:1];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_done_flag           <= 1'(`SBS_STATUS_RESET >> `SBS_BIT_BYTE_DONE); // [RULE2]
         received_ack_bit         <= 1'b1; // [RULE2]
         addressed_as_target_flag <= 1'b0;
         bus_busy_flag            <= 1'b0;
         arbitration_lost_flag    <= 1'b0;
         target_read_write_bit    <= 1'b0;
         interrupt_pending_flag   <= 1'b0;
      end else begin
         if (ninth_fall)
            byte_done_flag <= 1'b1; // [RULE3]
         else if (in_byte | (data_read_strobe & ~transmit_direction_bit) |
                  (data_write_strobe & transmit_direction_bit))
            byte_done_flag <= 1'b0; // [RULE3] [RULE20]

         if (addr_done & addr_match) begin
            addressed_as_target_flag <= 1'b1; // [RULE4]
            target_read_write_bit    <= shift[0]; // [RULE13]
         end else if (wr_control)
            addressed_as_target_flag <= 1'b0; // [RULE5]

         if (ev.start_seen)
            bus_busy_flag <= 1'b1; // [RULE6]
         else if (ev.stop_seen)
            bus_busy_flag <= 1'b0; // [RULE6]

         if (ack_rise & (transmit_direction_bit | phase == SBS_LINK_ADDRESS))
            received_ack_bit <= ev.sda_level; // [RULE17]

         // Set wins over a simultaneous software clear
         if (lost_any)
            arbitration_lost_flag <= 1'b1;
         else if (wr_status & ~hwdata[`SBS_BIT_ARB_LOST])
            arbitration_lost_flag <= 1'b0; // [RULE1] [RULE12]
         if (set_irq)
            interrupt_pending_flag <= 1'b1; // [RULE4]
         else if (wr_status & ~hwdata[`SBS_BIT_IRQ_PENDING])
            interrupt_pending_flag <= 1'b0; // [RULE1] [RULE12]
      end
   end

   wire [7:0] status_value = {byte_done_flag, addressed_as_target_flag, bus_busy_flag,
                              arbitration_lost_flag, 1'b0, target_read_write_bit,
                              interrupt_pending_flag, received_ack_bit}; // [RULE21]
   wire [7:0] read_value   = rd_status  ? status_value :
                             rd_control ? control :
                             rd_own     ? {own_address, 1'b0} : 8'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd_en)
         hrdata <= {24'h00_0000, read_value};
   end

   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign control_write_strobe = wr_control;
   assign serial_bus_control   = control;
   // Enable gates only the request; the pending flag is untouched
   assign irq = interrupt_pending_flag & interrupt_enable_bit; // [RULE15] [RULE19]
endmodule : sbs_status_top

// ===== tb/sbs_status_checker.sv
// Purpose: Port-level assertions for the status flag block.
// Assumes: Zero wait-state slave, hready tied to hreadyout.
// Notes:   Bound into sbs_status_top below the module.
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_status_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        hready,
   input wire logic        control_write_strobe,
   input wire logic [7:0]  serial_bus_control,
   input wire logic        irq
);
   logic        wr_dp;
   logic        rd_dp;
   logic [11:0] ad_q;
   // Data-phase view of the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp <= 1'b0;
         rd_dp <= 1'b0;
         ad_q  <= 12'h000;
      end else begin
         wr_dp <= hsel && hready && htrans[1] && hwrite;
         rd_dp <= hsel && hready && htrans[1] && !hwrite;
         ad_q  <= haddr[11:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_ctl_strobe: assert property (control_write_strobe == (wr_dp && ad_q == `SBS_OFS_CONTROL))
      else $error("control write strobe wrong");
   chk_ctl_written: assert property (control_write_strobe |=> serial_bus_control[7:6] == $past(hwdata[7:6])
      && serial_bus_control[4:3] == $past(hwdata[4:3]))
      else $error("control value not taken");
   chk_restart_zero: assert property (serial_bus_control[2:0] == 3'h0)
      else $error("control low bits not zero");
   chk_irq_gated: assert property (irq |-> serial_bus_control[`SBS_CTL_IRQ_ENABLE])
      else $error("interrupt without enable");
   chk_irq_holds: assert property (irq && !wr_dp |=> irq)
      else $error("interrupt dropped without write");
   chk_status_hole: assert property (rd_dp && (ad_q == `SBS_OFS_STATUS || ad_q == `SBS_OFS_STATUS_SECOND)
      |-> hrdata[3] == 1'b0 && hrdata[31:8] == 24'h0)
      else $error("status unused bits not zero");
   chk_unmapped_zero: assert property (rd_dp && ad_q[11:8] == 4'h0 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : sbs_status_checker

bind sbs_status_top sbs_status_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .hready(hready), .control_write_strobe(control_write_strobe),
   .serial_bus_control(serial_bus_control), .irq(irq));

// ===== tb/sbs_far_ctl.sv
// Purpose: Behavioural far-side bus controller driving SCL and SDA.
// Assumes: Pulled-up lines; 125 ns SCL period inside frames.
// Notes:   SCL stands high between frames.
`timescale 1ns/1ps
module sbs_far_ctl (
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task send_start;
      #62.5 sda = 1'b0;
      #62.5 scl = 1'b0;
   endtask : send_start
   // Eight bits msb first, then the acknowledge level
   task send_byte(input logic [7:0] b, input logic ack);
      for (int i = 8; i >= 0; i--) begin
         #31.25 sda = (i > 0) ? b[i-1] : ack;
         #31.25 scl = 1'b1;
         #62.5 scl = 1'b0;
      end
      // Released line goes to the pull-up level
      #31.25 sda = 1'b1;
   endtask : send_byte
   task send_stop;
      #31.25 sda = 1'b0;
      #31.25 scl = 1'b1;
      #62.5 sda = 1'b1;
   endtask : send_stop
endmodule : sbs_far_ctl

// ===== tb/test_sbs_status_top.sv
// Purpose: Self-checking bench for the status flag block.
// Assumes: Reads noted in a queue, judged by a monitor.
// Notes:   Strobe and drive-level inputs pulsed by the tests.
`timescale 1ns/1ps
`include "sbs_params.svh"
module test_sbs_status_top
   import sbs_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, start_request, data_read_strobe;
   logic [31:0] haddr, hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        sda_drive_high, data_write_strobe, rd_seen;
   wire  [31:0] hrdata;
   wire         hready, hresp, control_write_strobe, irq, scl_line, sda_line;
   wire  [7:0]  serial_bus_control;
   int          n_mismatch, n_tests, seed;
   logic [7:0]  q_exp[$], q_msk[$];
   logic [7:0]  mon_e, mon_m;
   logic [6:0]  own7;

   sbs_status_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .hready(hready), .scl_in(scl_line), .sda_in(sda_line),
      .sda_drive_high(sda_drive_high), .data_read_strobe(data_read_strobe),
      .data_write_strobe(data_write_strobe), .start_request(start_request),
      .control_write_strobe(control_write_strobe), .serial_bus_control(serial_bus_control), .irq(irq));
   sbs_far_ctl far (.scl(scl_line), .sda(sda_line));

   always #4 hclk = ~hclk;

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hready !== 1'b1);
   endtask : xfer

   task rd(input logic [11:0] a, input logic [7:0] ex, input logic [7:0] mk);
      q_exp.push_back(ex);
      q_msk.push_back(mk);
      xfer(1'b0, a, 8'h00);
   endtask : rd

   // Old data-phase flag and old hrdata are seen before this edge lands
   always @(posedge hclk) begin
      if (rd_seen && q_exp.size() > 0) begin
         mon_e = q_exp.pop_front();
         mon_m = q_msk.pop_front();
         check("register read", hrdata & {24'hFFFFFF, mon_m}, {24'h0, mon_e & mon_m});
      end
      rd_seen <= hsel && hready && htrans[1] && !hwrite;
   end

   task wrap_up;
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      #200000;
      n_mismatch++;
      wrap_up;
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      sda_drive_high = 1'b0;
      data_read_strobe = 1'b0;
      data_write_strobe = 1'b0;
      start_request = 1'b0;
      rd_seen = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      seed = $urandom(32'h4F0F);
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`SBS_OFS_STATUS, `SBS_STATUS_RESET, 8'hFF);
      rd(`SBS_OFS_STATUS_SECOND, `SBS_STATUS_RESET, 8'hFF);
      rd(`SBS_OFS_CONTROL, 8'h00, 8'hFF);
      rd(12'h000, 8'h00, 8'hFF);
      xfer(1'b1, `SBS_OFS_STATUS, 8'hFF);
      rd(`SBS_OFS_STATUS, `SBS_STATUS_RESET, 8'hFF);
      $display("Test reset values done");
      for (int rw = 0; rw < 2; rw++) begin
         own7 = 7'($urandom_range(8, 119));
         xfer(1'b1, `SBS_OFS_OWN_ADDRESS, {own7, 1'b0});
         xfer(1'b1, `SBS_OFS_CONTROL, 8'hC0);
         far.send_start();
         repeat (8) @(posedge hclk);
         rd(`SBS_OFS_STATUS, 8'h20, 8'h20);
         fork
            far.send_byte({own7, rw[0]}, own7[0]);
            begin
               repeat (40) @(posedge hclk);
               rd(`SBS_OFS_STATUS, 8'h00, 8'h80);
            end
         join
         repeat (8) @(posedge hclk);
         rd(`SBS_OFS_STATUS, {3'h7, 2'h0, rw[0], 1'b1, own7[0]}, 8'hFF);
         check("interrupt request", {31'h0, irq}, 32'h1);
         xfer(1'b1, `SBS_OFS_CONTROL, 8'h80);
         rd(`SBS_OFS_STATUS, 8'h02, 8'h42);
         check("interrupt request", {31'h0, irq}, 32'h0);
         @(posedge hclk) data_read_strobe <= 1'b1;
         @(posedge hclk) data_read_strobe <= 1'b0;
         xfer(1'b1, `SBS_OFS_STATUS, 8'h00);
         rd(`SBS_OFS_STATUS, 8'h00, 8'h92);
         far.send_stop();
         repeat (8) @(posedge hclk);
         rd(`SBS_OFS_STATUS_SECOND, 8'h00, 8'h20);
         $display("Test target address rw %0d done", rw);
      end
      xfer(1'b1, `SBS_OFS_CONTROL, 8'hC0);
      far.send_start();
      repeat (8) @(posedge hclk);
      @(posedge hclk) start_request <= 1'b1;
      @(posedge hclk) start_request <= 1'b0;
      repeat (4) @(posedge hclk);
      rd(`SBS_OFS_STATUS, 8'h32, 8'h32);
      check("interrupt request", {31'h0, irq}, 32'h1);
      xfer(1'b1, `SBS_OFS_STATUS, 8'h00);
      rd(`SBS_OFS_STATUS, 8'h20, 8'h32);
      xfer(1'b1, `SBS_OFS_CONTROL, 8'hC4);
      rd(`SBS_OFS_STATUS, 8'h12, 8'h12);
      xfer(1'b1, `SBS_OFS_STATUS, 8'h00);
      // Controller sends a one while the line carries a zero
      xfer(1'b1, `SBS_OFS_CONTROL, 8'hF0);
      sda_drive_high <= 1'b1;
      far.send_byte(8'h00, 1'b1);
      repeat (8) @(posedge hclk);
      sda_drive_high <= 1'b0;
      rd(`SBS_OFS_STATUS, 8'hB3, 8'hFB);
      check("control", {24'h0, serial_bus_control}, 32'hD0);
      @(posedge hclk) data_write_strobe <= 1'b1;
      @(posedge hclk) data_write_strobe <= 1'b0;
      xfer(1'b1, `SBS_OFS_STATUS, 8'h00);
      rd(`SBS_OFS_STATUS, 8'h00, 8'h92);
      // Stop on the bus while selected as controller, none requested
      xfer(1'b1, `SBS_OFS_CONTROL, 8'hE0);
      far.send_stop();
      repeat (8) @(posedge hclk);
      rd(`SBS_OFS_STATUS, 8'h12, 8'h32);
      check("control", {24'h0, serial_bus_control}, 32'hC0);
      xfer(1'b1, `SBS_OFS_STATUS, 8'h00);
      $display("Test arbitration done");
      wrap_up;
   end
endmodule : test_sbs_status_top
